// ==== include/t2cc_regs.svh ====
`ifndef T2CC_REGS_SVH
`define T2CC_REGS_SVH

`define T2CC_ADDR_MODE_CFG   8'hC1
`define T2CC_ADDR_CAP1_LOW   8'hC2
`define T2CC_ADDR_CAP1_HIGH  8'hC3
`define T2CC_ADDR_CAP2_LOW   8'hC4
`define T2CC_ADDR_CAP2_HIGH  8'hC5
`define T2CC_ADDR_CAP3_LOW   8'hC6
`define T2CC_ADDR_CAP3_HIGH  8'hC7
`define T2CC_ADDR_CONTROL    8'hC8
`define T2CC_ADDR_RELOAD_LOW 8'hCA
`define T2CC_ADDR_RELOAD_HI  8'hCB
`define T2CC_ADDR_COUNT_LOW  8'hCC
`define T2CC_ADDR_COUNT_HIGH 8'hCD

`define T2CC_RST_MODE_CFG    8'h00
`define T2CC_RST_CONTROL     8'h00
`define T2CC_RST_RELOAD      16'h0000
`define T2CC_RST_CAPTURE     16'h0000
`define T2CC_RST_COUNT       16'h0000

`define T2CC_CTL_PRESCALE    7
`define T2CC_CTL_IRQ3_EDGE   6
`define T2CC_CTL_IRQ2_EDGE   5
`define T2CC_CTL_RELOAD_HI   4
`define T2CC_CTL_RELOAD_LO   3
`define T2CC_CTL_CMP_MODE    2
`define T2CC_CTL_SRC_HI      1
`define T2CC_CTL_SRC_LO      0

`define T2CC_PRESCALE_SLOW   5'd12
`define T2CC_PRESCALE_FAST   5'd24

`define T2CC_MODE_OFF        2'b00
`define T2CC_MODE_COMPARE    2'b10
`define T2CC_MODE_CAPTURE    2'b11
`endif

// ==== include/t2cc_pkg.sv ====
package t2cc_pkg;
  typedef enum logic [1:0] {
    T2CC_SRC_STOP  = 2'b00,
    T2CC_SRC_CLOCK = 2'b01,
    T2CC_SRC_EDGE  = 2'b10,
    T2CC_SRC_GATED = 2'b11
  } t2cc_src_t;

  typedef struct packed {
    logic      prescale_select;
    logic      irq_three_edge_select;
    logic      irq_two_edge_select;
    logic [1:0] reload_mode_select;
    logic      compare_mode_select;
    t2cc_src_t count_source_select;
  } t2cc_ctl_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } t2cc_sfr_req_t;
endpackage

// ==== src/t2cc_top.sv ====
`timescale 1ns/100ps
`include "t2cc_regs.svh"
module t2cc_top
  import t2cc_pkg::*;
#(
  parameter int NUM_CAPTURE = 3
)
(
  input  wire logic          mclk,
  input  wire logic          sys_rst,
  input  wire t2cc_sfr_req_t sfr_req,
  output logic [7:0]         sfr_rdata,
  output logic               sfr_hit,
  input  wire logic          timer_ext_input,
  input  wire logic          low_freq_clock,
  output logic               compare_mode_select,
  output logic               irq_three_edge_select,
  output logic               irq_two_edge_select,
  output logic               compare_enable,
  output logic               overflow_pulse,
  output logic [15:0]        timer_value
);
  t2cc_ctl_t   ctl_q;
  logic [7:0]  mode_cfg_q;
  logic [15:0] reload_q;
  logic [15:0] count_q;
  logic [15:0] cap_q [NUM_CAPTURE];
  logic [4:0]  pre_cnt_q;
  logic        ext_q;
  logic        fall_q;
  logic        lf_q;
  logic        trig_q;
  logic        trig_prev_q;
  logic        tick;
  logic        step;
  logic        wrap;
  logic        reload_ev;
  logic [4:0]  pre_len;

  // the register map has byte pairs for exactly three capture registers
  if (NUM_CAPTURE != 3) begin : g_bad_capture_count
    $error("NUM_CAPTURE must be 3");
  end

  wire wr = sfr_req.wr;
  wire [7:0] a = sfr_req.addr;
  wire [7:0] wd = sfr_req.wdata;

  // prescaler runs only in clocked modes so the first step lands a full period after start
  assign pre_len = ctl_q.prescale_select ? `T2CC_PRESCALE_FAST : `T2CC_PRESCALE_SLOW;
  assign tick    = (pre_cnt_q == pre_len - 5'd1);

  always_ff @(posedge mclk) begin
    if (sys_rst || ctl_q.count_source_select == T2CC_SRC_STOP || tick) begin
      pre_cnt_q <= 5'd0;
    end else if (ctl_q.count_source_select != T2CC_SRC_EDGE) begin
      pre_cnt_q <= pre_cnt_q + 5'd1;
    end
  end

  // input sampled every edge; the falling edge is registered so the step comes a cycle later
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ext_q  <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      ext_q  <= timer_ext_input;
      fall_q <= ext_q && !timer_ext_input;
    end
  end

  always_comb begin
    case (ctl_q.count_source_select)
      T2CC_SRC_STOP:  step = 1'b0;
      T2CC_SRC_CLOCK: step = tick;
      T2CC_SRC_EDGE:  step = fall_q;
      T2CC_SRC_GATED: step = tick && timer_ext_input;
      default:        step = 1'b0;
    endcase
  end

  // reload trigger: low_freq_clock halved internally, sampled as a plain input
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lf_q        <= 1'b0;
      trig_q      <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      lf_q        <= low_freq_clock;
      trig_prev_q <= trig_q;
      if (low_freq_clock && !lf_q) begin
        trig_q <= !trig_q;
      end
    end
  end

  assign wrap = step && (count_q == 16'hFFFF);
  always_comb begin
    case (ctl_q.reload_mode_select)
      2'b10:   reload_ev = wrap;
      2'b11:   reload_ev = trig_prev_q && !trig_q;
      default: reload_ev = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_q <= `T2CC_RST_COUNT;
    end else if (reload_ev) begin
      count_q <= reload_q;
    end else if (wr && a == `T2CC_ADDR_COUNT_LOW) begin
      count_q[7:0] <= wd;
    end else if (wr && a == `T2CC_ADDR_COUNT_HIGH) begin
      count_q[15:8] <= wd;
    end else if (step) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctl_q      <= `T2CC_RST_CONTROL;
      mode_cfg_q <= `T2CC_RST_MODE_CFG;
    end else begin
      if (wr && a == `T2CC_ADDR_CONTROL) begin
        ctl_q <= wd;
      end
      if (wr && a == `T2CC_ADDR_MODE_CFG) begin
        mode_cfg_q <= wd;
      end
    end
  end

  // reload register; capture mode 11 replaces the low-byte write with the live count
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reload_q <= `T2CC_RST_RELOAD;
    end else if (wr && a == `T2CC_ADDR_RELOAD_LOW) begin
      if (mode_cfg_q[1:0] == `T2CC_MODE_CAPTURE) begin
        reload_q <= count_q;
      end else begin
        reload_q[7:0] <= wd;
      end
    end else if (wr && a == `T2CC_ADDR_RELOAD_HI) begin
      reload_q[15:8] <= wd;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CAPTURE; gi++) begin : g_cap
      localparam logic [7:0] LO = `T2CC_ADDR_CAP1_LOW + 8'(2 * gi);
      wire [1:0] md = mode_cfg_q[2*gi+3 -: 2];
      always_ff @(posedge mclk) begin
        if (sys_rst) begin
          cap_q[gi] <= `T2CC_RST_CAPTURE;
        end else if (wr && a == LO) begin
          if (md == `T2CC_MODE_CAPTURE) begin
            cap_q[gi] <= count_q;
          end else begin
            cap_q[gi][7:0] <= wd;
          end
        end else if (wr && a == LO + 8'h01) begin
          cap_q[gi][15:8] <= wd;
        end
      end

      a_cap_take: assert property (@(posedge mclk) disable iff (sys_rst)
        wr && a == LO && md == `T2CC_MODE_CAPTURE |=> cap_q[gi] == $past(count_q))
        else $error("capture register missed the count");
      a_cap_keep: assert property (@(posedge mclk) disable iff (sys_rst)
        wr && a == LO && md != `T2CC_MODE_CAPTURE |=> cap_q[gi][7:0] == $past(wd))
        else $error("capture low byte lost written data");
      a_cap_high: assert property (@(posedge mclk) disable iff (sys_rst)
        wr && a == LO + 8'h01 |=> cap_q[gi][15:8] == $past(wd))
        else $error("capture high byte lost written data");
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sfr_rdata <= 8'h00;
      sfr_hit   <= 1'b0;
    end else begin
      sfr_hit <= sfr_req.rd;
      case (a)
        `T2CC_ADDR_MODE_CFG:   sfr_rdata <= mode_cfg_q;
        `T2CC_ADDR_CAP1_LOW:   sfr_rdata <= cap_q[0][7:0];
        `T2CC_ADDR_CAP1_HIGH:  sfr_rdata <= cap_q[0][15:8];
        `T2CC_ADDR_CAP2_LOW:   sfr_rdata <= cap_q[1][7:0];
        `T2CC_ADDR_CAP2_HIGH:  sfr_rdata <= cap_q[1][15:8];
        `T2CC_ADDR_CAP3_LOW:   sfr_rdata <= cap_q[2][7:0];
        `T2CC_ADDR_CAP3_HIGH:  sfr_rdata <= cap_q[2][15:8];
        `T2CC_ADDR_CONTROL:    sfr_rdata <= ctl_q;
        `T2CC_ADDR_RELOAD_LOW: sfr_rdata <= reload_q[7:0];
        `T2CC_ADDR_RELOAD_HI:  sfr_rdata <= reload_q[15:8];
        `T2CC_ADDR_COUNT_LOW:  sfr_rdata <= count_q[7:0];
        `T2CC_ADDR_COUNT_HIGH: sfr_rdata <= count_q[15:8];
        default:               sfr_rdata <= 8'h00;
      endcase
    end
  end

  // status copies for the surrounding compare and interrupt logic
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      compare_mode_select   <= 1'b0;
      irq_three_edge_select <= 1'b0;
      irq_two_edge_select   <= 1'b0;
      compare_enable        <= 1'b0;
      overflow_pulse        <= 1'b0;
      timer_value           <= 16'h0000;
    end else begin
      compare_mode_select   <= ctl_q.compare_mode_select;
      irq_three_edge_select <= ctl_q.irq_three_edge_select;
      irq_two_edge_select   <= ctl_q.irq_two_edge_select;
      compare_enable        <= mode_cfg_q[1:0] == `T2CC_MODE_COMPARE;
      overflow_pulse        <= wrap;
      timer_value           <= count_q;
    end
  end

  a_stop_holds: assert property (@(posedge mclk) disable iff (sys_rst)
    ctl_q.count_source_select == T2CC_SRC_STOP && !wr && !reload_ev |=> $stable(count_q))
    else $error("timer moved while stopped");
  a_gate_low: assert property (@(posedge mclk) disable iff (sys_rst)
    ctl_q.count_source_select == T2CC_SRC_GATED && !timer_ext_input |-> !step)
    else $error("gated timer stepped with input low");
  a_edge_step: assert property (@(posedge mclk) disable iff (sys_rst)
    ctl_q.count_source_select == T2CC_SRC_EDGE && $fell(ext_q) |-> step)
    else $error("falling edge not counted");
  a_prescale_len: assert property (@(posedge mclk) disable iff (sys_rst)
    tick |-> pre_cnt_q == (ctl_q.prescale_select ? 5'd23 : 5'd11))
    else $error("prescale period wrong");
  a_reload_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    reload_ev |=> count_q == $past(reload_q))
    else $error("reload value not loaded");
  a_reload_off: assert property (@(posedge mclk) disable iff (sys_rst)
    !ctl_q.reload_mode_select[1] |-> !reload_ev)
    else $error("reload while disabled");
  a_capture_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    wr && a == `T2CC_ADDR_CAP1_LOW && mode_cfg_q[3:2] == `T2CC_MODE_CAPTURE
    |=> cap_q[0] == $past(count_q))
    else $error("capture lost count");
  a_count_read: assert property (@(posedge mclk) disable iff (sys_rst)
    a == `T2CC_ADDR_COUNT_LOW |=> sfr_rdata == $past(count_q[7:0]))
    else $error("count read stale");

  // multi-step behaviours are spelled as sequences so the cycle of each step is explicit
  sequence s_edge_fall_seen;
    ctl_q.count_source_select == T2CC_SRC_EDGE && ext_q && !timer_ext_input;
  endsequence
  sequence s_still_edge;
    ctl_q.count_source_select == T2CC_SRC_EDGE;
  endsequence
  sequence s_ctrl_write;
    wr && a == `T2CC_ADDR_CONTROL;
  endsequence
  sequence s_trig_fall;
    ctl_q.reload_mode_select == 2'b11 && trig_prev_q && !trig_q;
  endsequence

  a_event_delay: assert property (@(posedge mclk) disable iff (sys_rst)
    s_edge_fall_seen ##1 s_still_edge |-> step)
    else $error("event step not one cycle after the fall");
  a_clock_step: assert property (@(posedge mclk) disable iff (sys_rst)
    ctl_q.count_source_select == T2CC_SRC_CLOCK |-> step == tick)
    else $error("clocked timer step off the prescaler");
  a_gate_high: assert property (@(posedge mclk) disable iff (sys_rst)
    ctl_q.count_source_select == T2CC_SRC_GATED && timer_ext_input && tick |-> step)
    else $error("gated timer missed a step with input high");
  a_trig_reload: assert property (@(posedge mclk) disable iff (sys_rst)
    s_trig_fall |-> reload_ev)
    else $error("trigger fall did not reload");
  a_wrap_reload: assert property (@(posedge mclk) disable iff (sys_rst)
    ctl_q.reload_mode_select == 2'b10 && wrap |-> reload_ev)
    else $error("overflow did not reload");
  a_overflow_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    wrap |=> overflow_pulse)
    else $error("overflow pulse missing");
  a_ctrl_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    s_ctrl_write |=> ##1 compare_mode_select == $past(wd[`T2CC_CTL_CMP_MODE], 2))
    else $error("compare mode copy wrong");
  a_irq_copy: assert property (@(posedge mclk) disable iff (sys_rst)
    s_ctrl_write |=> ##1 irq_three_edge_select == $past(wd[`T2CC_CTL_IRQ3_EDGE], 2)
      && irq_two_edge_select == $past(wd[`T2CC_CTL_IRQ2_EDGE], 2))
    else $error("irq edge copy wrong");
  a_crc_capture: assert property (@(posedge mclk) disable iff (sys_rst)
    wr && a == `T2CC_ADDR_RELOAD_LOW && mode_cfg_q[1:0] == `T2CC_MODE_CAPTURE
    |=> reload_q == $past(count_q))
    else $error("reload register missed the capture");
  a_crc_store: assert property (@(posedge mclk) disable iff (sys_rst)
    wr && a == `T2CC_ADDR_RELOAD_LOW && mode_cfg_q[1:0] != `T2CC_MODE_CAPTURE
    |=> reload_q[7:0] == $past(wd))
    else $error("reload low byte lost written data");
  a_crc_high: assert property (@(posedge mclk) disable iff (sys_rst)
    wr && a == `T2CC_ADDR_RELOAD_HI |=> reload_q[15:8] == $past(wd))
    else $error("reload high byte lost written data");
  a_count_high: assert property (@(posedge mclk) disable iff (sys_rst)
    wr && a == `T2CC_ADDR_COUNT_HIGH && !reload_ev |=> count_q[15:8] == $past(wd))
    else $error("count high byte write lost");
  a_cmp_enable: assert property (@(posedge mclk) disable iff (sys_rst)
    1'b1 |=> compare_enable == ($past(mode_cfg_q[1:0]) == `T2CC_MODE_COMPARE))
    else $error("compare enable does not follow the mode field");
  a_read_mark: assert property (@(posedge mclk) disable iff (sys_rst)
    sfr_req.rd |=> sfr_hit)
    else $error("read not marked");
endmodule

// ==== testbench/t2cc_cpu_model.sv ====
`timescale 1ns/100ps
module t2cc_cpu_model
  import t2cc_pkg::*;
(
  input  wire logic       mclk,
  output t2cc_sfr_req_t   sfr_req,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic       sfr_hit
);
  initial sfr_req = '0;
  // request moves 1 ns after the edge, so the core never samples it mid-change
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    sfr_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk) #1;
    sfr_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge mclk) #1;
    sfr_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge mclk) #1;
    q = {sfr_hit, sfr_rdata};
    sfr_req.rd = 1'b0;
  endtask
endmodule

// ==== testbench/t2cc_top_tb.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module t2cc_top_tb;
  import t2cc_pkg::*;
  logic          mclk = 1'b0;
  logic          sys_rst = 1'b1;
  t2cc_sfr_req_t sfr_req;
  logic [7:0]    sfr_rdata;
  logic          sfr_hit;
  logic          ext_in = 1'b0;
  logic          lf_clk = 1'b0;
  logic          cms, irq3, irq2, cmp_en, ovf;
  logic [15:0]   timer_value;
  int            n_fail = 0;
  int            cmp_count = 0;
  always #2.5 mclk = ~mclk;
  t2cc_top t2cc_top_inst (.mclk(mclk), .sys_rst(sys_rst), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .timer_ext_input(ext_in),
    .low_freq_clock(lf_clk), .compare_mode_select(cms),
    .irq_three_edge_select(irq3), .irq_two_edge_select(irq2),
    .compare_enable(cmp_en), .overflow_pulse(ovf), .timer_value(timer_value));
  t2cc_cpu_model t2cc_cpu_model_inst (.mclk(mclk), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    t2cc_cpu_model_inst.wr(a, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [8:0] q;
    t2cc_cpu_model_inst.rd(a, q);
    `CHK(q, {1'b1, e})
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // settle two cycles first: a step may still land on the edge of a mode change
  task automatic delta(input int n, input logic [15:0] e);
    logic [15:0] t0;
    cyc(2);
    t0 = timer_value;
    cyc(n);
    `CHK(timer_value - t0, e)
  endtask
  task automatic t_reset();
    for (int a = 'hc1; a <= 'hcd; a++) rchk(8'(a), 8'h00);
    `CHK({cms, irq3, irq2, cmp_en, ovf}, 5'h00)
  endtask
  task automatic t_ctrl();
    logic [7:0] v [3] = '{8'h64, 8'h40, 8'h24};
    logic [2:0] e [3] = '{3'h7, 3'h2, 3'h5};
    for (int i = 0; i < 3; i++) begin
      wr(8'hc8, v[i]);
      cyc(1);
      `CHK({cms, irq3, irq2}, e[i])
      rchk(8'hc8, v[i]);
    end
  endtask
  task automatic t_count();
    wr(8'hc8, 8'h01);
    delta(48, 16'h0004);
    wr(8'hc8, 8'h81);
    cyc(24);
    delta(48, 16'h0002);
    wr(8'hc8, 8'h00);
    delta(48, 16'h0000);
    wr(8'hc8, 8'h03);
    delta(48, 16'h0000);
    ext_in = 1'b1;
    delta(48, 16'h0004);
  endtask
  task automatic t_event();
    logic [15:0] t0;
    ext_in = 1'b0;
    cyc(2);
    wr(8'hc8, 8'h02);
    cyc(2);
    t0 = timer_value;
    // one fall every second cycle, the fastest rate the input allows
    for (int i = 0; i < 5; i++) begin
      ext_in = 1'b1;
      cyc(1);
      ext_in = 1'b0;
      cyc(1);
    end
    cyc(4);
    `CHK(timer_value - t0, 16'h0005)
  endtask
  task automatic t_capture();
    wr(8'hc8, 8'h00);
    wr(8'hcc, 8'h34);
    wr(8'hcd, 8'h12);
    rchk(8'hcd, 8'h12);
    wr(8'hc1, 8'hfc);
    for (int a = 'hc2; a <= 'hc6; a += 2) begin
      wr(8'(a), 8'h99);
      rchk(8'(a), 8'h34);
      rchk(8'(a + 1), 8'h12);
    end
    wr(8'hc1, 8'h98);
    wr(8'hc4, 8'h5a);
    rchk(8'hc4, 8'h5a);
    wr(8'hca, 8'h66);
    rchk(8'hca, 8'h66);
    wr(8'hc1, 8'h03);
    wr(8'hca, 8'h99);
    rchk(8'hca, 8'h34);
    rchk(8'hcb, 8'h12);
    wr(8'hc1, 8'h02);
    cyc(1);
    `CHK(cmp_en, 1'b1)
    wr(8'hc1, 8'h01);
    cyc(1);
    `CHK(cmp_en, 1'b0)
  endtask
  task automatic t_reload();
    int n = 0;
    wr(8'hca, 8'hf0);
    wr(8'hcb, 8'hff);
    wr(8'hcc, 8'hfe);
    wr(8'hcd, 8'hff);
    wr(8'hc8, 8'h11);
    while (ovf !== 1'b1 && n < 60) begin
      cyc(1);
      n++;
    end
    if (ovf !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    cyc(1);
    `CHK(ovf, 1'b0)
    `CHK(timer_value, 16'hfff0)
    wr(8'hc8, 8'h18);
    wr(8'hcc, 8'h00);
    wr(8'hcd, 8'h00);
    repeat (3) begin
      lf_clk = 1'b1;
      cyc(4);
      lf_clk = 1'b0;
      cyc(4);
    end
    `CHK(timer_value, 16'hfff0)
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(8);
    sys_rst = 1'b0;
    t_reset();
    t_ctrl();
    t_count();
    t_event();
    t_capture();
    t_reload();
    stop_test();
  end
endmodule
